// ---- core/watchdog_control_pkg.sv ----
/*
 * constants, types and register map for the watchdog control block.
 * assumes a 250 MHz ref_clk and an APB master with 32-bit data.
 */
package watchdog_control_pkg;

    // clock and timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned LED_HALF_MS = 500;
    localparam int unsigned LED_HALF_CYCLES = LED_HALF_MS * 1000 * CLK_MHZ;
    localparam int unsigned SECOND_MS = 1000;
    localparam int unsigned SECOND_CYCLES = SECOND_MS * 1000 * CLK_MHZ;
    localparam int unsigned DELAY_STEP_MS = 10;
    localparam int unsigned DELAY_STEP_CYCLES = DELAY_STEP_MS * 1000 * CLK_MHZ;
    localparam logic [5:0] MINUTE_SECONDS = 6'h3C;

    // register indices; byte address is four times the index
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_CFG_MODE = 10'h000;
    localparam logic [IDX_W-1:0] IDX_MIR_GP1 = 10'h001;
    localparam logic [IDX_W-1:0] IDX_MIR_CTRL = 10'h002;
    localparam logic [IDX_W-1:0] IDX_MIR_GP5 = 10'h003;
    localparam logic [IDX_W-1:0] IDX_MIR_GP6 = 10'h004;
    localparam logic [IDX_W-1:0] IDX_MIR_LAST = 10'h00F;
    localparam logic [IDX_W-1:0] IDX_DELAY = 10'h0B8;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0E0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0E1;
    localparam logic [IDX_W-1:0] IDX_PIN_EN_A = 10'h0E2;
    localparam logic [IDX_W-1:0] IDX_PIN_EN_B = 10'h0E3;
    localparam logic [IDX_W-1:0] IDX_UNITS = 10'h0F1;
    localparam logic [IDX_W-1:0] IDX_VALUE = 10'h0F2;
    localparam logic [IDX_W-1:0] IDX_CFG = 10'h0F3;
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0F4;
    localparam logic [IDX_W-1:0] IDX_GP1 = 10'h0F6;
    localparam logic [IDX_W-1:0] IDX_GP5 = 10'h0F9;
    localparam logic [IDX_W-1:0] IDX_GP6 = 10'h0FA;
    localparam logic [IDX_W-1:0] IDX_NONE = 10'h3FF;

    // reset values and masks
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;
    localparam logic [7:0] DELAY_RESET = 8'h32;
    localparam logic [7:0] GP5_MASK = 8'h1D;
    localparam logic [7:0] UNITS_MASK = 8'h80;
    localparam logic [7:0] CFG_MASK = 8'h07;
    localparam int UNITS_SEC_BIT = 7;
    localparam int CFG_GAME_BIT = 0;
    localparam int CFG_KBD_BIT = 1;
    localparam int CFG_MOUSE_BIT = 2;

    // control register layout, bit 7 first
    typedef struct packed {
        logic powerDown;
        logic restart;
        logic stopped;
        logic reserved;
        logic kbcForceEn;
        logic forceTimeout;
        logic ledToggleEn;
        logic status;
    } ctrl_s;

    // interrupt status and mask layout
    typedef struct packed {
        logic powerDown;
        logic timeout;
    } evt_s;

    typedef enum logic [2:0] {
        DLY_IDLE = 3'b001,
        DLY_RUN = 3'b010,
        DLY_STOP = 3'b100
    } dly_e;

endpackage : watchdog_control_pkg

// ---- core/watchdog_control.sv ----
/*
 * watchdog control, power-button delay, power LED blink and pin snapshot
 * registers behind an APB slave. assumes pins and neighbouring-block
 * strobes arrive asynchronously and are synchronised here.
 */
// Functional notes
// - control bit 0 is timeout status, readable and writable.
// - LED toggle enable blinks power LED at 1 Hz, half on half off.
// - writing force-timeout bit raises a timeout; bit self-clears.
// - keyboard-line enable lets its rising edge raise a timeout.
// - keyboard line edge-detected, pulse ORed with force pulse.
// - stop bit ends button delay without power down; reads 1 when stopped.
// - restart bit reloads full button delay; unlimited; self-clears.
// - control bit 7 forces immediate power down; self-clears.
// - delay length comes from delay-time register at index B8.
// - three read-only pin snapshot registers at F6, F9, FA.
// - outside config mode, pin and control registers mirrored at 01-04.
// - group 1 feeds combined irq a; groups 5 and 6 feed irq b.
// - timeout value binary; zero disables, one gives one unit.
// - unit select bit 7: 0 minutes, 1 seconds.
// - counter restarted by enabled game port, keyboard, mouse activity.
`timescale 1ns/100ps
module watchdog_control #(
    parameter int unsigned LED_HALF = watchdog_control_pkg::LED_HALF_CYCLES,
    parameter int unsigned SECOND = watchdog_control_pkg::SECOND_CYCLES,
    parameter int unsigned DELAY_STEP = watchdog_control_pkg::DELAY_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic kbcForceLine,
    input wire logic powerButton,
    input wire logic gamePortAccess,
    input wire logic keyboardIrq,
    input wire logic mouseIrq,
    input wire logic [7:0] pinGroupOne,
    input wire logic [7:0] pinGroupFive,
    input wire logic [7:0] pinGroupSix,
    output logic powerLed,
    output logic softPowerDown,
    output logic wdtTimeout,
    output logic combinedPinIrqA,
    output logic combinedPinIrqB,
    output logic irq
);
    import watchdog_control_pkg::*;

    localparam int LW = $clog2(LED_HALF + 1);
    localparam int SW = $clog2(SECOND + 1);
    localparam int DW = $clog2(DELAY_STEP + 1);

    function automatic logic [IDX_W-1:0] homeIdx(input logic [IDX_W-1:0] idx,
                                                 input logic cfgMode);
        logic [IDX_W-1:0] r;
        r = idx;
        if (!cfgMode && idx >= IDX_MIR_GP1 && idx <= IDX_MIR_LAST)
        begin
            unique case (idx)
                IDX_MIR_GP1: r = IDX_GP1;
                IDX_MIR_CTRL: r = IDX_CTRL;
                IDX_MIR_GP5: r = IDX_GP5;
                IDX_MIR_GP6: r = IDX_GP6;
                default: r = IDX_NONE;
            endcase
        end
        else if (idx >= IDX_MIR_GP1 && idx <= IDX_MIR_LAST)
        begin
            r = IDX_NONE;
        end
        return r;
    endfunction : homeIdx

    // synchronisers: stage one feeds stage two only
    localparam int SYNC_W = 26;
    localparam int S_MOUSE = 21;
    localparam int S_KBD = 22;
    localparam int S_GAME = 23;
    localparam int S_BUTTON = 24;
    localparam int S_KBC = 25;
    logic [SYNC_W-1:0] syncA_q;
    logic [SYNC_W-1:0] syncB_q;
    logic [SYNC_W-1:0] prevB_q;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            syncA_q <= '0;
            syncB_q <= '0;
            prevB_q <= '0;
        end
        else
        begin
            syncA_q <= {kbcForceLine, powerButton, gamePortAccess, keyboardIrq, mouseIrq,
                        pinGroupSix, pinGroupFive[4:0], pinGroupOne};
            syncB_q <= syncA_q;
            prevB_q <= syncB_q;
        end
    end
    logic [SYNC_W-1:0] rise;
    assign rise = syncB_q & ~prevB_q;

    // registers
    ctrl_s ctrl_q;
    logic cfgMode_q;
    logic [7:0] delaySet_q;
    logic [7:0] units_q;
    logic [7:0] value_q;
    logic [7:0] cfg_q;
    logic [7:0] gp1_q;
    logic [7:0] gp5_q;
    logic [7:0] gp6_q;
    logic [7:0] pinEnA_q;
    logic [7:0] pinEnB_q;
    evt_s irqStatus_q;
    evt_s irqMask_q;

    // apb: one wait state, answer registered
    logic access;
    logic [IDX_W-1:0] idx;
    logic wrDone;
    logic rdTake;
    assign access = psel && penable;
    assign idx = homeIdx(paddr[11:2], cfgMode_q);
    assign wrDone = access && pwrite && pready;
    // read-clear at the capture edge, so a wait-state event is kept
    assign rdTake = access && !pwrite && !pready;

    logic [7:0] rdMux;
    logic hit;
    always_comb
    begin
        rdMux = 8'h00;
        hit = 1'b1;
        unique case (idx)
            IDX_CFG_MODE: rdMux = {7'h00, cfgMode_q};
            IDX_DELAY: rdMux = delaySet_q;
            IDX_IRQ_STATUS: rdMux = {6'h00, irqStatus_q};
            IDX_IRQ_MASK: rdMux = {6'h00, irqMask_q};
            IDX_PIN_EN_A: rdMux = pinEnA_q;
            IDX_PIN_EN_B: rdMux = pinEnB_q;
            IDX_UNITS: rdMux = units_q;
            IDX_VALUE: rdMux = value_q;
            IDX_CFG: rdMux = cfg_q;
            // write-only strobes read back as zero
            IDX_CTRL: rdMux = {1'b0, 1'b0, ctrl_q.stopped, 1'b0, ctrl_q.kbcForceEn,
                               1'b0, ctrl_q.ledToggleEn, ctrl_q.status};
            IDX_GP1: rdMux = gp1_q;
            IDX_GP5: rdMux = gp5_q;
            IDX_GP6: rdMux = gp6_q;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access && !pready;
            prdata <= (access && !pready && !pwrite) ? {24'h000000, rdMux} : '0;
            pslverr <= access && !pready && !hit;
        end
    end

    logic wrCtrl;
    assign wrCtrl = wrDone && hit && idx == IDX_CTRL;

    // plain configuration registers
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cfgMode_q <= 1'b0;
            delaySet_q <= DELAY_RESET;
            units_q <= CTRL_RESET;
            value_q <= CTRL_RESET;
            cfg_q <= CTRL_RESET;
            pinEnA_q <= CTRL_RESET;
            pinEnB_q <= CTRL_RESET;
            irqMask_q <= '0;
        end
        else if (wrDone)
        begin
            unique case (idx)
                IDX_CFG_MODE: cfgMode_q <= pwdata[0];
                IDX_DELAY: delaySet_q <= pwdata[7:0];
                IDX_IRQ_MASK: irqMask_q <= pwdata[1:0];
                IDX_PIN_EN_A: pinEnA_q <= pwdata[7:0];
                IDX_PIN_EN_B: pinEnB_q <= pwdata[7:0];
                IDX_UNITS: units_q <= pwdata[7:0] & UNITS_MASK;
                IDX_VALUE: value_q <= pwdata[7:0];
                IDX_CFG: cfg_q <= pwdata[7:0] & CFG_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            gp1_q <= PIN_RESET;
            gp5_q <= PIN_RESET;
            gp6_q <= PIN_RESET;
        end
        else
        begin
            gp1_q <= syncB_q[7:0];
            gp5_q <= {3'b000, syncB_q[12:8]} & GP5_MASK;
            gp6_q <= syncB_q[20:13];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            combinedPinIrqA <= 1'b0;
            combinedPinIrqB <= 1'b0;
        end
        else
        begin
            combinedPinIrqA <= |(gp1_q & pinEnA_q);
            combinedPinIrqB <= |(gp5_q & pinEnB_q) | |(gp6_q & pinEnB_q);
        end
    end

    // watchdog counter
    logic [SW-1:0] secCnt_q;
    logic [5:0] minCnt_q;
    logic [7:0] unitCnt_q;
    logic secTick;
    logic unitTick;
    logic kick;
    logic expiry;
    assign secTick = secCnt_q == SW'(SECOND - 1);
    assign unitTick = secTick && (units_q[UNITS_SEC_BIT] || minCnt_q == MINUTE_SECONDS - 6'h01);
    assign kick = (cfg_q[CFG_GAME_BIT] && rise[S_GAME]) || (cfg_q[CFG_KBD_BIT] && rise[S_KBD])
                  || (cfg_q[CFG_MOUSE_BIT] && rise[S_MOUSE]) || (wrDone && idx == IDX_VALUE);
    assign expiry = unitTick && value_q != 8'h00 && unitCnt_q == value_q - 8'h01;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || kick || value_q == 8'h00)
        begin
            secCnt_q <= '0;
            minCnt_q <= '0;
            unitCnt_q <= '0;
        end
        else
        begin
            secCnt_q <= secTick ? '0 : secCnt_q + SW'(1);
            if (secTick)
            begin
                minCnt_q <= unitTick ? 6'h00 : minCnt_q + 6'h01;
            end
            if (unitTick)
            begin
                unitCnt_q <= expiry ? 8'h00 : unitCnt_q + 8'h01;
            end
        end
    end

    // force pulse ORed with edge pulse; the line may stay high forever
    logic timeoutEvt;
    assign timeoutEvt = expiry || (wrCtrl && pwdata[2]) || (ctrl_q.kbcForceEn && rise[S_KBC]);

    // power-button delay
    dly_e dly_q;
    logic [7:0] dlyCnt_q;
    logic [DW-1:0] stepCnt_q;
    logic stepTick;
    logic dlyDone;
    logic spoffWr;
    assign stepTick = stepCnt_q == DW'(DELAY_STEP - 1);
    assign dlyDone = dly_q == DLY_RUN && stepTick && dlyCnt_q <= 8'h01;
    assign spoffWr = wrCtrl && pwdata[7];

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            dly_q <= DLY_IDLE;
            dlyCnt_q <= 8'h00;
            stepCnt_q <= '0;
        end
        // restart from zero, full delay, any number of times
        else if (wrCtrl && pwdata[6])
        begin
            dly_q <= DLY_RUN;
            dlyCnt_q <= delaySet_q;
            stepCnt_q <= '0;
        end
        else if (wrCtrl && pwdata[5])
        begin
            dly_q <= DLY_STOP;
        end
        else
        begin
            unique case (dly_q)
                DLY_IDLE, DLY_STOP:
                begin
                    if (rise[S_BUTTON])
                    begin
                        dly_q <= DLY_RUN;
                        dlyCnt_q <= delaySet_q;
                        stepCnt_q <= '0;
                    end
                end
                DLY_RUN:
                begin
                    stepCnt_q <= stepTick ? '0 : stepCnt_q + DW'(1);
                    if (dlyDone || spoffWr)
                    begin
                        dly_q <= DLY_IDLE;
                    end
                    else if (stepTick)
                    begin
                        dlyCnt_q <= dlyCnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // control register
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else
        begin
            // timeout sets, software write decides otherwise; set wins
            ctrl_q.status <= timeoutEvt || (wrCtrl ? pwdata[0] : ctrl_q.status);
            if (wrCtrl)
            begin
                ctrl_q.ledToggleEn <= pwdata[1];
                ctrl_q.kbcForceEn <= pwdata[3];
            end
            // reserved bit held at zero whatever is written
            ctrl_q.reserved <= 1'b0;
            ctrl_q.forceTimeout <= 1'b0;
            ctrl_q.restart <= 1'b0;
            ctrl_q.powerDown <= 1'b0;
            // reads 1 unless the delay counter runs
            ctrl_q.stopped <= dly_q != DLY_RUN;
        end
    end

    logic [LW-1:0] ledCnt_q;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || !ctrl_q.ledToggleEn)
        begin
            ledCnt_q <= '0;
            powerLed <= 1'b0;
        end
        else if (ledCnt_q == LW'(LED_HALF - 1))
        begin
            ledCnt_q <= '0;
            powerLed <= !powerLed;
        end
        else
        begin
            ledCnt_q <= ledCnt_q + LW'(1);
        end
    end

    // event pulses and interrupt; status read clears, new event wins
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wdtTimeout <= 1'b0;
            softPowerDown <= 1'b0;
            irqStatus_q <= '0;
            irq <= 1'b0;
        end
        else
        begin
            wdtTimeout <= timeoutEvt;
            softPowerDown <= dlyDone || spoffWr;
            irqStatus_q.timeout <= timeoutEvt
                || (irqStatus_q.timeout && !(rdTake && idx == IDX_IRQ_STATUS));
            irqStatus_q.powerDown <= dlyDone || spoffWr
                || (irqStatus_q.powerDown && !(rdTake && idx == IDX_IRQ_STATUS));
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

endmodule : watchdog_control

// ---- sim/watchdog_control_chk.sv ----
/* assertions on the apb answer, control strobes and event pulses.
   assumes a bind onto watchdog_control, one clock domain. */
`timescale 1ns/100ps
module watchdog_control_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic softPowerDown,
    input wire logic wdtTimeout
);
    import watchdog_control_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // end of an access, as the slave sees it
    wire logic done = psel && penable && pready;
    wire logic ctrlWr = done && pwrite && paddr == {IDX_CTRL, 2'b00};
    wire logic ctrlRd = done && !pwrite && paddr == {IDX_CTRL, 2'b00};
    wire logic gp5Rd = done && !pwrite && paddr == {IDX_GP5, 2'b00};
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_idle_data: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    a_err_pair: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without answer");
    a_force_pulse: assert property (ctrlWr && pwdata[2] |=> wdtTimeout)
        else $error("force write gave no timeout");
    a_power_down: assert property (ctrlWr && pwdata[7] |=> softPowerDown)
        else $error("power down write gave no pulse");
    a_timeout_once: assert property (wdtTimeout |=> !wdtTimeout)
        else $error("timeout pulse too long");
    a_ctrl_selfclr: assert property (ctrlRd |-> prdata[7:6] == 2'b00 && !prdata[2])
        else $error("self clearing bit reads one");
    a_gp5_resv: assert property (gp5Rd |-> (prdata[7:0] & ~GP5_MASK) == 8'h00)
        else $error("reserved pin bit set");
endmodule : watchdog_control_chk

bind watchdog_control watchdog_control_chk u_chk (.ref_clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .softPowerDown, .wdtTimeout);

// ---- sim/watchdog_control_tb.sv ----
/* self-checking bench for watchdog_control: apb master, pins, strobes.
   assumes short LED, second and delay-step counts set here. */
`timescale 1ns/100ps
module watchdog_control_tb;
    import watchdog_control_pkg::*;
    localparam int LH = 8;
    logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic kbcForceLine, powerButton, gamePortAccess, keyboardIrq, mouseIrq;
    logic [7:0] pinGroupOne, pinGroupFive, pinGroupSix;
    logic powerLed, softPowerDown, wdtTimeout, combinedPinIrqA, combinedPinIrqB, irq;
    int error_cnt = 0;
    int n_checks = 0;
    int toCnt = 0;
    int pdCnt = 0;
    logic [9:0] pinIdx [6] = '{IDX_GP1, IDX_GP5, IDX_GP6, IDX_MIR_GP1, IDX_MIR_GP5, IDX_MIR_GP6};

    watchdog_control #(.LED_HALF(LH), .SECOND(16), .DELAY_STEP(4)) DUT (.ref_clk, .reset_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .kbcForceLine,
        .powerButton, .gamePortAccess, .keyboardIrq, .mouseIrq, .pinGroupOne, .pinGroupFive,
        .pinGroupSix, .powerLed, .softPowerDown, .wdtTimeout, .combinedPinIrqA,
        .combinedPinIrqB, .irq);

    initial
    begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (wdtTimeout === 1'b1) toCnt++;
        if (softPowerDown === 1'b1) pdCnt++;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge ref_clk);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // group five only has four real pins
    function automatic logic [31:0] pinExp(input int j);
        case (j % 3)
            0: return {24'h0, pinGroupOne};
            1: return {24'h0, pinGroupFive & GP5_MASK};
            default: return {24'h0, pinGroupSix};
        endcase
    endfunction : pinExp

    initial
    begin
        int t0, p0, on;
        {psel, penable, pwrite, kbcForceLine, powerButton} = '0;
        {gamePortAccess, keyboardIrq, mouseIrq, paddr, pwdata} = '0;
        {pinGroupOne, pinGroupFive, pinGroupSix} = '0;
        reset_n = 0;
        rd = $urandom(55069);
        cyc(20);
        reset_n <= 1'b1;
        apb(0, IDX_CTRL, 0);
        chk("ctrl reset", rd, 32'h20);
        apb(0, IDX_NONE, 0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 4; i++)
        begin
            pinGroupOne <= 8'($urandom);
            pinGroupFive <= 8'($urandom);
            pinGroupSix <= 8'($urandom);
            apb(1, IDX_GP1, 8'hFF);
            cyc(4);
            for (int j = 0; j < 6; j++)
            begin
                apb(0, pinIdx[j], 0);
                chk("pins", rd, pinExp(j));
            end
        end
        pinGroupOne <= 8'h10;
        pinGroupFive <= 8'h00;
        pinGroupSix <= 8'h80;
        apb(1, IDX_PIN_EN_A, 8'hFF);
        apb(1, IDX_PIN_EN_B, 8'hFF);
        cyc(5);
        chk("pin irqs", {combinedPinIrqA, combinedPinIrqB}, 2'b11);
        apb(1, IDX_PIN_EN_A, 8'h00);
        cyc(3);
        chk("pin irq a off", combinedPinIrqA, 0);
        $display("pin test done");
        apb(1, IDX_IRQ_MASK, 8'h01);
        apb(1, IDX_CTRL, 8'h04);
        cyc(4);
        chk("irq raised", irq, 1);
        apb(0, IDX_CTRL, 0);
        chk("status set", rd[0], 1);
        apb(0, IDX_IRQ_STATUS, 0);
        chk("event bits", rd, 32'h1);
        cyc(3);
        chk("irq cleared", irq, 0);
        apb(1, IDX_CTRL, 8'h00);
        apb(0, IDX_CTRL, 0);
        chk("status clr", rd[0], 0);
        apb(1, IDX_IRQ_MASK, 8'h00);
        apb(1, IDX_CTRL, 8'h04);
        cyc(4);
        chk("irq masked", irq, 0);
        apb(0, IDX_IRQ_STATUS, 0);
        apb(1, IDX_CTRL, 8'h00);
        $display("force test done");
        t0 = toCnt;
        kbcForceLine <= 1'b1;
        cyc(6);
        kbcForceLine <= 1'b0;
        cyc(4);
        chk("kbc off", toCnt - t0, 0);
        apb(1, IDX_CTRL, 8'h08);
        kbcForceLine <= 1'b1;
        cyc(40);
        chk("kbc once", toCnt - t0, 1);
        apb(0, IDX_CTRL, 0);
        chk("kbc status", rd, 32'h29);
        kbcForceLine <= 1'b0;
        apb(1, IDX_CTRL, 8'h00);
        $display("kbc test done");
        apb(1, IDX_DELAY, 8'h03);
        p0 = pdCnt;
        powerButton <= 1'b1;
        cyc(5);
        apb(0, IDX_CTRL, 0);
        chk("running", rd[5], 0);
        apb(1, IDX_CTRL, 8'h20);
        cyc(30);
        chk("stopped no pd", pdCnt - p0, 0);
        apb(0, IDX_CTRL, 0);
        chk("stopped", rd[5], 1);
        powerButton <= 1'b0;
        cyc(3);
        powerButton <= 1'b1;
        cyc(4);
        apb(1, IDX_CTRL, 8'h40);
        cyc(5);
        apb(1, IDX_CTRL, 8'h40);
        cyc(5);
        chk("restart held", pdCnt - p0, 0);
        cyc(20);
        chk("delay expiry", pdCnt - p0, 1);
        apb(1, IDX_CTRL, 8'h80);
        cyc(2);
        chk("soft off", pdCnt - p0, 2);
        apb(0, IDX_IRQ_STATUS, 0);
        chk("pd event", rd, 32'h3);
        powerButton <= 1'b0;
        $display("delay test done");
        apb(1, IDX_CTRL, 8'h02);
        cyc(3);
        on = 0;
        repeat (4 * LH)
        begin
            @(posedge ref_clk);
            on += int'(powerLed === 1'b1);
        end
        chk("led duty", on, 2 * LH);
        apb(1, IDX_CTRL, 8'h00);
        cyc(3);
        chk("led off", powerLed, 0);
        apb(1, IDX_CFG_MODE, 8'h01);
        apb(0, IDX_MIR_CTRL, 0);
        chk("cfg mode", err, 1);
        apb(1, IDX_CFG_MODE, 8'h00);
        apb(0, IDX_MIR_CTRL, 0);
        chk("mirror", {rd[30:0], err}, 32'h40);
        $display("led and mirror test done");
        apb(1, IDX_UNITS, 8'h80);
        apb(1, IDX_CFG, 8'h02);
        apb(1, IDX_VALUE, 8'h02);
        repeat (6)
        begin
            cyc(10);
            keyboardIrq <= 1'b1;
            cyc(10);
            keyboardIrq <= 1'b0;
        end
        apb(0, IDX_CTRL, 0);
        chk("kicked", rd[0], 0);
        cyc(60);
        apb(0, IDX_CTRL, 0);
        chk("expired", rd[0], 1);
        apb(1, IDX_CFG, 8'h05);
        apb(1, IDX_VALUE, 8'h02);
        apb(1, IDX_CTRL, 8'h00);
        repeat (3)
        begin
            cyc(10);
            gamePortAccess <= 1'b1;
            cyc(10);
            gamePortAccess <= 1'b0;
            cyc(10);
            mouseIrq <= 1'b1;
            cyc(10);
            mouseIrq <= 1'b0;
        end
        apb(0, IDX_CTRL, 0);
        chk("game mouse kick", rd[0], 0);
        apb(1, IDX_VALUE, 8'h00);
        apb(1, IDX_CTRL, 8'h00);
        cyc(80);
        apb(0, IDX_CTRL, 0);
        chk("disabled", rd[0], 0);
        $display("watchdog test done");
        summarize();
    end
endmodule : watchdog_control_tb
